// ==== verilog/iprs_top.sv ====
// Contract
// - Reference_input_config bit 5 puts primary, bit 6 secondary, into single-ended CMOS mode.
// - Differential receiver off when differential not selected or input loop powered down.
// - Single-ended buffer off on loop power-down, own power-down, or differential selected.
// - Secondary divider follows primary unless 0x01C bit 7 enables independent division.
// - Oscillator feedback receiver configuration comes from 0x01A bits 1 to 0.
// - Oscillator feedback receiver off while 0x233 bit 2 is one.
// - Lock timeout equals ten reciprocal loop bandwidths.
// - Each reference has its own divider, ratio 1 through 1023.
// - Monitor judges divided references and steers switchover.
// - Manual reference choice by register setting or select pin.
// - Automatic mode moves to secondary when primary lost and secondary present.
// - Nonrevertive stays on secondary, returns only when secondary is lost.
// - Revertive returns to primary as soon as primary is present.
// - Both references absent means holdover, loop runs from external oscillator.
// - Entering holdover tristates the charge pump unless mid-supply is chosen.
// - Holdover ends when a reference returns; loop then resynchronises.
// - Input_loop_misc_control bit 6 drives charge pump to mid-supply in holdover.
// - In automatic mode one detected reference becomes active; with two, one active, one backup.
`timescale 1ns/100ps
module iprs_top
   import iprs_pkg::*;
#(
   parameter int LOCK_TIMEOUT_CYCLES = LOCK_TIMEOUT_CYC,
   parameter int LOSS_CYCLES         = LOSS_CYC
) (
   input  wire logic              mclk,
   input  wire logic              rst,
   // Register port from the serial control interface.
   input  wire logic              reg_wr_en,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wr_data,
   output logic      [DATA_W-1:0] reg_rd_data,
   // Reference clocks, sampled on mclk.
   input  wire logic              primary_reference,
   input  wire logic              secondary_reference,
   input  wire logic              reference_select_pin,
   // Configuration levels held outside the three mapped registers.
   input  wire logic [DIV_W-1:0]  primary_divider,
   input  wire logic [DIV_W-1:0]  secondary_divider,
   input  wire logic              primary_buffer_pd,
   input  wire logic              secondary_buffer_pd,
   input  wire logic              auto_switch_en,
   input  wire logic              revertive_en,
   input  wire logic              manual_use_pin,
   input  wire logic              manual_select_secondary,
   // Analog control outputs.
   output logic [1:0]             osc_rx_config,
   output logic                   osc_rx_pd,
   output logic [NUM_REF-1:0]     diff_rx_pd,
   output logic [NUM_REF-1:0]     se_buffer_pd,
   output logic                   cp_tristate,
   output logic                   cp_mid_supply,
   output logic                   pfd_ref_pulse,
   // Status.
   output logic                   primary_present,
   output logic                   secondary_present,
   output logic                   active_is_secondary,
   output logic                   holdover,
   output logic                   lock_settling,
   output logic                   switch_event
);

   logic [DATA_W-1:0]  ref_input_config;
   logic [DATA_W-1:0]  input_loop_misc_control;
   logic [DATA_W-1:0]  power_down_control;
   logic [DATA_W-1:0]  next_rd_data;
   iprs_state_t        state;
   iprs_state_t        next_state;
   logic [TIMER_W-1:0] lock_timer;
   logic [NUM_REF-1:0] ref_pins;
   logic [NUM_REF-1:0] cmos_sel;
   logic [NUM_REF-1:0] buf_pd_set;
   logic [NUM_REF-1:0] rx_enable;
   logic [NUM_REF-1:0] div_pulse;
   logic [NUM_REF-1:0] present;
   logic [DIV_W-1:0]   ratio [NUM_REF];

   // Register write decode.
   wire wr_ref_cfg  = reg_wr_en && (reg_addr == REG_REF_INPUT_CFG);
   wire wr_misc     = reg_wr_en && (reg_addr == REG_LOOP_MISC_CTRL);
   wire wr_pd       = reg_wr_en && (reg_addr == REG_POWER_DOWN);

   always_ff @(posedge mclk) begin
      if (rst) begin
         ref_input_config        <= RST_REF_INPUT_CFG;
         input_loop_misc_control <= RST_LOOP_MISC_CTRL;
         power_down_control      <= RST_POWER_DOWN;
      end else begin
         if (wr_ref_cfg) begin
            ref_input_config <= reg_wr_data;
         end
         if (wr_misc) begin
            input_loop_misc_control <= reg_wr_data;
         end
         if (wr_pd) begin
            power_down_control <= reg_wr_data;
         end
      end
   end

   // Read data is registered, so it follows the address one cycle later.
   always_comb begin
      if (reg_addr == REG_REF_INPUT_CFG) begin
         next_rd_data = ref_input_config;
      end else if (reg_addr == REG_LOOP_MISC_CTRL) begin
         next_rd_data = input_loop_misc_control;
      end else if (reg_addr == REG_POWER_DOWN) begin
         next_rd_data = power_down_control;
      end else begin
         next_rd_data = RD_UNMAPPED;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         reg_rd_data <= RD_UNMAPPED;
      end else begin
         reg_rd_data <= next_rd_data;
      end
   end

   // Field extraction.
   wire loop_pd     = power_down_control[LOOP_PD_BIT];
   wire indep_div   = input_loop_misc_control[INDEP_DIV_BIT];
   wire mid_supply  = input_loop_misc_control[MID_SUPPLY_BIT];

   assign cmos_sel[CH_PRI]   = ref_input_config[PRI_CMOS_BIT];
   assign cmos_sel[CH_SEC]   = ref_input_config[SEC_CMOS_BIT];
   assign buf_pd_set[CH_PRI] = primary_buffer_pd;
   assign buf_pd_set[CH_SEC] = secondary_buffer_pd;
   assign ref_pins[CH_PRI]   = primary_reference;
   assign ref_pins[CH_SEC]   = secondary_reference;

   assign ratio[CH_PRI] = primary_divider;
   assign ratio[CH_SEC] = indep_div ? secondary_divider : primary_divider;

   // A bypass setup relies on software keeping loop_pd clear, or the
   // oscillator receiver goes down with the rest of the input loop.
   assign osc_rx_config = ref_input_config[OSC_CFG_MSB:OSC_CFG_LSB];
   assign osc_rx_pd     = loop_pd;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_REF; gi++) begin : g_ref
         wire diff_off = loop_pd | cmos_sel[gi];
         wire se_off   = loop_pd | buf_pd_set[gi] | ~cmos_sel[gi];

         assign diff_rx_pd[gi]   = diff_off;
         assign se_buffer_pd[gi] = se_off;
         // The reference reaches the divider only through a powered receiver.
         assign rx_enable[gi]    = cmos_sel[gi] ? ~se_off : ~diff_off;

         iprs_ref_channel #(
            .LOSS_CYCLES (LOSS_CYCLES)
         ) u_chan (
            .mclk         (mclk),
            .rst          (rst),
            .ref_in       (ref_pins[gi]),
            .rx_enable    (rx_enable[gi]),
            .divide_ratio (ratio[gi]),
            .div_pulse    (div_pulse[gi]),
            .present      (present[gi])
         );
      end
   endgenerate

   wire pa = present[CH_PRI];
   wire pb = present[CH_SEC];

   // Manual choice comes from the pin or from the register-held level.
   wire manual_sec = manual_use_pin ? reference_select_pin : manual_select_secondary;

   always_comb begin
      next_state = state;
      if (!pa && !pb) begin
         next_state = IPRS_HOLDOVER;
      end else if (!auto_switch_en) begin
         if (manual_sec) begin
            next_state = IPRS_ON_SECONDARY;
         end else begin
            next_state = IPRS_ON_PRIMARY;
         end
      end else begin
         case (state)
            IPRS_ON_PRIMARY: begin
               if (!pa) begin
                  next_state = IPRS_ON_SECONDARY;
               end
            end
            IPRS_ON_SECONDARY: begin
               if (revertive_en && pa) begin
                  next_state = IPRS_ON_PRIMARY;
               end else if (!pb) begin
                  next_state = IPRS_ON_PRIMARY;
               end
            end
            IPRS_HOLDOVER: begin
               if (pa) begin
                  next_state = IPRS_ON_PRIMARY;
               end else begin
                  next_state = IPRS_ON_SECONDARY;
               end
            end
            default: begin
               next_state = IPRS_HOLDOVER;
            end
         endcase
      end
   end

   // In manual mode a chosen but absent reference is kept while the other one is present; the loop then
   // simply sees no edges, as the user asked for that input explicitly.
   wire state_change = (next_state != state);
   wire to_reference = state_change && (next_state != IPRS_HOLDOVER);

   always_ff @(posedge mclk) begin
      if (rst) begin
         state        <= IPRS_HOLDOVER;
         switch_event <= 1'b0;
      end else begin
         state        <= next_state;
         switch_event <= state_change;
      end
   end

   // Settling window after each new reference, sized to ten loop time constants.
   always_ff @(posedge mclk) begin
      if (rst) begin
         lock_timer <= '0;
      end else if (to_reference) begin
         lock_timer <= TIMER_W'(LOCK_TIMEOUT_CYCLES);
      end else if (next_state == IPRS_HOLDOVER) begin
         lock_timer <= '0;
      end else if (lock_timer != '0) begin
         lock_timer <= lock_timer - 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         pfd_ref_pulse <= 1'b0;
      end else begin
         case (state)
            IPRS_ON_PRIMARY:   pfd_ref_pulse <= div_pulse[CH_PRI];
            IPRS_ON_SECONDARY: pfd_ref_pulse <= div_pulse[CH_SEC];
            default:           pfd_ref_pulse <= 1'b0;
         endcase
      end
   end

   assign holdover            = (state == IPRS_HOLDOVER);
   assign cp_tristate         = holdover & ~mid_supply;
   assign cp_mid_supply       = holdover & mid_supply;
   assign active_is_secondary = (state == IPRS_ON_SECONDARY);
   assign lock_settling       = (lock_timer != '0);
   assign primary_present     = pa;
   assign secondary_present   = pb;

endmodule

// ==== verilog/iprs_pkg.sv ====
package iprs_pkg;

   // Register map, addressed by the 10-bit serial-port address.
   localparam int          ADDR_W             = 10;
   localparam int          DATA_W             = 8;
   localparam logic [9:0]  REG_REF_INPUT_CFG  = 10'h01A;
   localparam logic [9:0]  REG_LOOP_MISC_CTRL = 10'h01C;
   localparam logic [9:0]  REG_POWER_DOWN     = 10'h233;

   // Reset values of the three registers.
   localparam logic [7:0]  RST_REF_INPUT_CFG  = 8'h00;
   localparam logic [7:0]  RST_LOOP_MISC_CTRL = 8'h00;
   localparam logic [7:0]  RST_POWER_DOWN     = 8'h00;
   localparam logic [7:0]  RD_UNMAPPED        = 8'h00;

   // Field positions.
   localparam int          OSC_CFG_LSB        = 0;
   localparam int          OSC_CFG_MSB        = 1;
   localparam int          PRI_CMOS_BIT       = 5;
   localparam int          SEC_CMOS_BIT       = 6;
   localparam int          MID_SUPPLY_BIT     = 6;
   localparam int          INDEP_DIV_BIT      = 7;
   localparam int          LOOP_PD_BIT        = 2;

   // Reference divider range.
   localparam int          DIV_W              = 10;
   localparam logic [9:0]  DIV_MIN            = 10'h001;
   localparam logic [9:0]  DIV_MAX            = 10'h3FF;

   // Lock timing: ten loop time constants, each the reciprocal of the loop bandwidth.
   localparam int          CLK_HZ             = 50_000_000;
   localparam int          LOCK_TC_COUNT      = 10;
   localparam int          LOOP_BW_HZ         = 100;
   localparam int          LOCK_TIMEOUT_CYC   = LOCK_TC_COUNT * (CLK_HZ / LOOP_BW_HZ);
   localparam int          TIMER_W            = 32;

   // Reference monitor silence limit, in oscillator clock cycles.
   localparam int          LOSS_CYC           = 1024;
   localparam int          LOSS_W             = 16;

   // Channel indices.
   localparam int          CH_PRI             = 0;
   localparam int          CH_SEC             = 1;
   localparam int          NUM_REF            = 2;

   typedef enum logic [1:0] {
      IPRS_ON_PRIMARY,
      IPRS_ON_SECONDARY,
      IPRS_HOLDOVER
   } iprs_state_t;

endpackage

// ==== verilog/iprs_ref_channel.sv ====
`timescale 1ns/100ps
module iprs_ref_channel
   import iprs_pkg::*;
#(
   parameter int LOSS_CYCLES = LOSS_CYC
) (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             ref_in,
   input  wire logic             rx_enable,
   input  wire logic [DIV_W-1:0] divide_ratio,
   output logic                  div_pulse,
   output logic                  present
);

   logic             ref_prev;
   logic [DIV_W-1:0] edge_count;
   logic [LOSS_W-1:0] silence;
   wire              ref_gated = ref_in & rx_enable;
   wire              ref_rise  = ref_gated & ~ref_prev;
   // A ratio of zero is outside the range and is treated as divide by one.
   wire [DIV_W-1:0]  ratio     = (divide_ratio < DIV_MIN) ? DIV_MIN : divide_ratio;
   wire              div_hit   = ref_rise && (edge_count >= ratio - DIV_MIN);
   wire              timed_out = (silence >= LOSS_W'(LOSS_CYCLES - 1));

   always_ff @(posedge mclk) begin
      if (rst) begin
         ref_prev   <= 1'b0;
         edge_count <= '0;
         div_pulse  <= 1'b0;
      end else begin
         ref_prev   <= ref_gated;
         div_pulse  <= div_hit;
         if (div_hit) begin
            edge_count <= '0;
         end else if (ref_rise) begin
            edge_count <= edge_count + DIV_MIN;
         end
      end
   end

   // Presence is judged on the divided signal, so the limit must exceed
   // the divided period or a healthy slow reference will look lost.
   always_ff @(posedge mclk) begin
      if (rst) begin
         silence <= '0;
         present <= 1'b0;
      end else if (div_pulse) begin
         silence <= '0;
         present <= 1'b1;
      end else if (timed_out) begin
         present <= 1'b0;
      end else begin
         silence <= silence + 1'b1;
      end
   end

endmodule

// ==== testbench/iprs_ref_source.sv ====
`timescale 1ns/100ps
module iprs_ref_source #(
   parameter int HALF_PRI = 2,
   parameter int HALF_SEC = 3
) (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic run_pri,
   input  wire logic run_sec,
   output logic      primary_reference,
   output logic      secondary_reference
);
   int cnt_pri;
   int cnt_sec;
   // A stopped source parks low, as a lost reference input would.
   always_ff @(posedge mclk) begin
      if (rst || !run_pri) begin
         cnt_pri <= 0;
         primary_reference <= 1'b0;
      end else if (cnt_pri == HALF_PRI - 1) begin
         cnt_pri <= 0;
         primary_reference <= !primary_reference;
      end else begin
         cnt_pri <= cnt_pri + 1;
      end
   end
   // Different half period keeps the two references unrelated in phase.
   always_ff @(posedge mclk) begin
      if (rst || !run_sec) begin
         cnt_sec <= 0;
         secondary_reference <= 1'b0;
      end else if (cnt_sec == HALF_SEC - 1) begin
         cnt_sec <= 0;
         secondary_reference <= !secondary_reference;
      end else begin
         cnt_sec <= cnt_sec + 1;
      end
   end
endmodule

// ==== testbench/iprs_top_assertions.sv ====
`timescale 1ns/100ps
module iprs_top_assertions
   import iprs_pkg::*;
(
   input wire logic               mclk,
   input wire logic               rst,
   input wire logic               reg_wr_en,
   input wire logic [ADDR_W-1:0]  reg_addr,
   input wire logic [DATA_W-1:0]  reg_wr_data,
   input wire logic [DATA_W-1:0]  reg_rd_data,
   input wire logic               primary_buffer_pd,
   input wire logic               secondary_buffer_pd,
   input wire logic               auto_switch_en,
   input wire logic               revertive_en,
   input wire logic               manual_use_pin,
   input wire logic               manual_select_secondary,
   input wire logic [1:0]         osc_rx_config,
   input wire logic               osc_rx_pd,
   input wire logic [NUM_REF-1:0] diff_rx_pd,
   input wire logic [NUM_REF-1:0] se_buffer_pd,
   input wire logic               cp_tristate,
   input wire logic               cp_mid_supply,
   input wire logic               primary_present,
   input wire logic               secondary_present,
   input wire logic               active_is_secondary,
   input wire logic               holdover,
   input wire logic               pfd_ref_pulse,
   input wire logic               lock_settling,
   input wire logic               switch_event
);
   logic [7:0] cfg;
   logic [7:0] misc;
   logic [7:0] pwr;
   logic [7:0] rd_exp;
   logic       p;
   logic       s;
   logic       on_ref;
   // Shadow copies of the registers, rebuilt from the write port alone.
   always_ff @(posedge mclk) begin
      if (rst) begin
         cfg <= RST_REF_INPUT_CFG;
         misc <= RST_LOOP_MISC_CTRL;
         pwr <= RST_POWER_DOWN;
      end else if (reg_wr_en) begin
         if (reg_addr == REG_REF_INPUT_CFG) cfg <= reg_wr_data;
         if (reg_addr == REG_LOOP_MISC_CTRL) misc <= reg_wr_data;
         if (reg_addr == REG_POWER_DOWN) pwr <= reg_wr_data;
      end
   end
   assign rd_exp = (reg_addr == REG_REF_INPUT_CFG) ? cfg : (reg_addr == REG_LOOP_MISC_CTRL) ? misc
                 : (reg_addr == REG_POWER_DOWN) ? pwr : RD_UNMAPPED;
   assign p = primary_present;
   assign s = secondary_present;
   assign on_ref = !holdover;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_read_back: assert property (1 |=> reg_rd_data == $past(rd_exp))
      else $error("read data differs from register");
   a_osc_cfg_copy: assert property (osc_rx_config == cfg[1:0])
      else $error("oscillator receiver config wrong");
   a_osc_rx_off: assert property (osc_rx_pd == pwr[2])
      else $error("oscillator receiver power-down wrong");
   a_diff_rx_off: assert property (diff_rx_pd == {pwr[2] | cfg[6], pwr[2] | cfg[5]})
      else $error("differential receiver power-down wrong");
   a_se_buf_off: assert property (
      se_buffer_pd == {pwr[2] | secondary_buffer_pd | !cfg[6],
      pwr[2] | primary_buffer_pd | !cfg[5]})
      else $error("single-ended buffer power-down wrong");
   a_cp_hold_mode: assert property (
      cp_tristate == (holdover && !misc[6]) && cp_mid_supply == (holdover && misc[6]))
      else $error("charge pump holdover drive wrong");
   a_hold_enter: assert property (!p && !s |=> holdover)
      else $error("no holdover with both references lost");
   a_hold_exit: assert property (holdover && (p || s) |=> on_ref)
      else $error("holdover kept with a reference present");
   a_auto_switch: assert property (
      auto_switch_en && on_ref && !active_is_secondary && !p && s
      |=> on_ref && active_is_secondary)
      else $error("no switch to secondary");
   a_auto_revert: assert property (
      auto_switch_en && revertive_en && on_ref
      && active_is_secondary && p |=> on_ref && !active_is_secondary)
      else $error("no return to primary");
   a_stay_second: assert property (
      auto_switch_en && !revertive_en && on_ref
      && active_is_secondary && s |=> active_is_secondary)
      else $error("left secondary while present");
   a_manual_pick: assert property (
      !auto_switch_en && !manual_use_pin && manual_select_secondary
      && (p || s) |=> on_ref && active_is_secondary)
      else $error("manual selection ignored");
   a_switch_flag: assert property (
      switch_event == $changed({active_is_secondary, holdover}))
      else $error("switch event pulse wrong");
   a_pfd_quiet: assert property ($past(holdover) |-> !pfd_ref_pulse)
      else $error("phase detector fed during holdover");
   a_settle_start: assert property (switch_event && !holdover |-> lock_settling)
      else $error("no settling window after switch");
   a_hold_settle: assert property (holdover |-> !lock_settling)
      else $error("settling window kept in holdover");
endmodule
bind iprs_top iprs_top_assertions u_chk (.mclk(mclk), .rst(rst), .reg_wr_en(reg_wr_en),
   .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
   .primary_buffer_pd(primary_buffer_pd), .secondary_buffer_pd(secondary_buffer_pd),
   .auto_switch_en(auto_switch_en), .revertive_en(revertive_en),
   .manual_use_pin(manual_use_pin), .manual_select_secondary(manual_select_secondary),
   .osc_rx_config(osc_rx_config), .osc_rx_pd(osc_rx_pd), .diff_rx_pd(diff_rx_pd),
   .se_buffer_pd(se_buffer_pd), .cp_tristate(cp_tristate), .cp_mid_supply(cp_mid_supply),
   .primary_present(primary_present), .secondary_present(secondary_present),
   .active_is_secondary(active_is_secondary), .holdover(holdover),
   .pfd_ref_pulse(pfd_ref_pulse), .lock_settling(lock_settling), .switch_event(switch_event));

// ==== testbench/input_pll_reference_switchover_bench.sv ====
`timescale 1ns/100ps
module input_pll_reference_switchover_bench;
   import iprs_pkg::*;
   localparam int LOSS = 64;
   logic       mclk = 1'b0;
   logic       rst = 1'b1;
   logic       wr_en = 1'b0;
   logic [9:0] addr = 10'h000;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic       run_pri = 1'b0;
   logic       run_sec = 1'b0;
   logic       pin = 1'b0;
   logic       bpd0 = 1'b0;
   logic       bpd1 = 1'b0;
   logic       auto = 1'b0;
   logic       rev = 1'b0;
   logic       use_pin = 1'b0;
   logic       man_sec = 1'b0;
   logic [9:0] div0 = 10'h003;
   logic [9:0] div1 = 10'h064;
   logic [1:0] osc_cfg;
   logic [1:0] dpd;
   logic [1:0] spd;
   logic       osc_pd, cp_t, cp_m, p_pres, s_pres, act_sec, hold, lock_s, pri_ref, sec_ref;
   int         n_fail = 0;
   int         n_compared = 0;
   iprs_ref_source u_src (.mclk(mclk), .rst(rst), .run_pri(run_pri), .run_sec(run_sec),
      .primary_reference(pri_ref), .secondary_reference(sec_ref));
   iprs_top #(.LOCK_TIMEOUT_CYCLES(50), .LOSS_CYCLES(LOSS)) u_dut (.mclk(mclk), .rst(rst),
      .reg_wr_en(wr_en), .reg_addr(addr), .reg_wr_data(wdata), .reg_rd_data(rdata),
      .primary_reference(pri_ref), .secondary_reference(sec_ref), .reference_select_pin(pin),
      .primary_divider(div0), .secondary_divider(div1), .primary_buffer_pd(bpd0),
      .secondary_buffer_pd(bpd1), .auto_switch_en(auto), .revertive_en(rev),
      .manual_use_pin(use_pin), .manual_select_secondary(man_sec), .osc_rx_config(osc_cfg),
      .osc_rx_pd(osc_pd), .diff_rx_pd(dpd), .se_buffer_pd(spd), .cp_tristate(cp_t),
      .cp_mid_supply(cp_m), .pfd_ref_pulse(), .primary_present(p_pres),
      .secondary_present(s_pres), .active_is_secondary(act_sec), .holdover(hold),
      .lock_settling(lock_s), .switch_event());
   initial begin
      forever #10 mclk = !mclk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge mclk);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [9:0] a, input logic [7:0] exp);
      @(posedge mclk);
      addr <= a;
      @(posedge mclk);
      #1 check(rdata, exp);
   endtask
   // Bounded wait for the switchover state, then judged.
   task automatic wait_state(input logic sec, input logic hld);
      for (int i = 0; i < 400 && !(act_sec === sec && hold === hld); i++) begin
         @(posedge mclk);
         #1;
      end
      check({act_sec, hold}, {sec, hld});
   endtask
   task automatic t_regs;
      rd(REG_REF_INPUT_CFG, RST_REF_INPUT_CFG);
      rd(REG_POWER_DOWN, RST_POWER_DOWN);
      check(hold, 1'b1);
      bpd0 <= 1'b1;
      wr(REG_REF_INPUT_CFG, 8'h63);
      wr(10'h01B, 8'hFF);
      rd(10'h01B, RD_UNMAPPED);
      rd(REG_REF_INPUT_CFG, 8'h63);
      check(osc_cfg, 2'b11);
      check({dpd, spd}, 4'b1101);
      bpd0 <= 1'b0;
      bpd1 <= 1'b1;
      #20 check({dpd, spd}, 4'b1110);
      wr(REG_POWER_DOWN, 8'h04);
      #1 check({osc_pd, dpd, spd}, 5'h1F);
      wr(REG_REF_INPUT_CFG, 8'h00);
      wr(REG_POWER_DOWN, 8'h00);
      #1 check({osc_pd, dpd, spd}, 5'h03);
   endtask
   // Primary ratio 3 keeps pulses inside the loss limit; 100 and 1023 do not.
   task automatic t_div;
      @(posedge mclk);
      run_pri <= 1'b1;
      run_sec <= 1'b1;
      repeat (4 * LOSS) @(posedge mclk);
      #1 check({p_pres, s_pres}, 2'b11);
      wr(REG_LOOP_MISC_CTRL, 8'h80);
      repeat (4 * LOSS) @(posedge mclk);
      #1 check({p_pres, s_pres}, 2'b10);
      div1 <= 10'h3FF;
      repeat (4 * LOSS) @(posedge mclk);
      #1 check(s_pres, 1'b0);
      div1 <= 10'h001;
      repeat (4 * LOSS) @(posedge mclk);
      #1 check(s_pres, 1'b1);
      wr(REG_LOOP_MISC_CTRL, 8'h00);
   endtask
   task automatic t_auto;
      auto <= 1'b1;
      rev <= 1'b1;
      wait_state(1'b0, 1'b0);
      run_pri <= 1'b0;
      wait_state(1'b1, 1'b0);
      run_pri <= 1'b1;
      wait_state(1'b0, 1'b0);
      rev <= 1'b0;
      run_pri <= 1'b0;
      wait_state(1'b1, 1'b0);
      run_pri <= 1'b1;
      repeat (4 * LOSS) @(posedge mclk);
      #1 check(act_sec, 1'b1);
      run_sec <= 1'b0;
      wait_state(1'b0, 1'b0);
   endtask
   task automatic t_hold;
      run_pri <= 1'b0;
      wait_state(1'b0, 1'b1);
      check({cp_t, cp_m}, 2'b10);
      wr(REG_LOOP_MISC_CTRL, 8'h40);
      #1 check({cp_t, cp_m}, 2'b01);
      run_sec <= 1'b1;
      wait_state(1'b1, 1'b0);
      check(lock_s, 1'b1);
      repeat (48) @(posedge mclk);
      #1 check(lock_s, 1'b1);
      repeat (4) @(posedge mclk);
      #1 check(lock_s, 1'b0);
   endtask
   task automatic t_manual;
      auto <= 1'b0;
      run_pri <= 1'b1;
      wait_state(1'b0, 1'b0);
      man_sec <= 1'b1;
      wait_state(1'b1, 1'b0);
      use_pin <= 1'b1;
      wait_state(1'b0, 1'b0);
      pin <= 1'b1;
      wait_state(1'b1, 1'b0);
   endtask
   task automatic close_out;
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      t_regs();
      t_div();
      t_auto();
      t_hold();
      t_manual();
      close_out();
   end
   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      close_out();
   end
endmodule
